// >>> hw/pih_params.svh
/*
 * Constants of the issue interlock and hazard spacing block: producer
 * wait counts, hazard class indices and instruction spacings.
 * Assumes inclusion by its bare name from the block's design files.
 */
`ifndef PIH_PARAMS_SVH
`define PIH_PARAMS_SVH

// ----------------------------------------------------------------------
// Register file shape and counter widths
// ----------------------------------------------------------------------
`define PIH_NUM_GPR         32
`define PIH_WAIT_W          3
`define PIH_SPACE_W         4

// ----------------------------------------------------------------------
// Producer waits, counted to the address-generation consumer;
// the execute-stage consumer waits one cycle less
// ----------------------------------------------------------------------
`define PIH_WAIT_NONE       3'h0
`define PIH_WAIT_LOAD       3'h2
`define PIH_WAIT_SYSREG_RD  3'h3
`define PIH_WAIT_MULTIPLY   3'h5

// ----------------------------------------------------------------------
// Hazard classes (index into the pending vector)
// ----------------------------------------------------------------------
`define PIH_HZ_NUM          7
`define PIH_HZ_XLATE_LS     0
`define PIH_HZ_SYSREG_RD    1
`define PIH_HZ_TIMER        2
`define PIH_HZ_COPROC       3
`define PIH_HZ_LS_STATE     4
`define PIH_HZ_OTHER        5
`define PIH_HZ_FETCH        6

// ----------------------------------------------------------------------
// Spacings in issued instructions
// ----------------------------------------------------------------------
`define PIH_SP_XLATE_LS     4'h3
`define PIH_SP_SYSREG_RD    4'h2
`define PIH_SP_TIMER        4'h4
`define PIH_SP_COPROC       4'h4
`define PIH_SP_LS_STATE     4'h3
`define PIH_SP_OTHER        4'h2
`define PIH_SP_FETCH        4'ha

`endif

// >>> hw/pih_pkg.sv
/*
 * Types of the issue interlock and hazard spacing block.
 * Assumes the constants header is compiled alongside it.
 */
package pih_pkg;

	// ------------------------------------------------------------------
	// Instruction classes seen at issue
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_OTHER, OP_ALU, OP_LOAD, OP_STORE, OP_SYSREG_READ, OP_SYSREG_WRITE,
		OP_REG_MULTIPLY, OP_MOVE_FROM_HIGH, OP_MOVE_FROM_LOW,
		OP_XLATE_WRITE_RANDOM, OP_XLATE_WRITE_INDEXED, OP_CACHE_IWRITE,
		OP_EXEC_BARRIER, OP_EXCEPTION_RETURN, OP_JUMP_BARRIER, OP_JUMP_LINK_BARRIER
	} pih_op_e;

	// Target of a system-control register write
	typedef enum logic [3:0] {
		SR_OTHER, SR_TIMER_CMP, SR_COPROC_USABLE, SR_FLOAT_REG_MODE,
		SR_ADDR_SPACE_ID, SR_ERROR_LEVEL, SR_EXCEPTION_LEVEL,
		SR_DEBUG_LS_NORMAL_MEM, SR_WATCH
	} pih_sysreg_e;

	// How a source operand is consumed
	typedef enum logic [1:0] {USE_NONE, USE_ALU, USE_BASE} pih_use_e;

	// Stage that slips
	typedef enum logic [1:0] {SLIP_NONE, SLIP_EX, SLIP_AG} pih_slip_e;

	typedef logic [2:0] pih_wait_t;
	typedef logic [3:0] pih_space_t;

	// Instruction presented for issue
	typedef struct packed {
		pih_op_e     op;
		pih_sysreg_e target;
		logic [4:0]  dest;
		logic [4:0]  src_a;
		pih_use_e    use_a;
		logic [4:0]  src_b;
		pih_use_e    use_b;
	} pih_instr_s;

	// Issue status of the held instruction
	typedef struct packed {
		logic      fire;
		logic      stall;
		pih_slip_e slip;
	} pih_issue_s;

endpackage

// >>> hw/pih_interlock.sv
/*
 * Issue interlock and hazard spacing tracker for an in-order pipeline.
 * Assumes decode on the same clock presents one instruction at a time
 * with valid/ready, and the register file port busy flag is same-clock.
 */
`timescale 1ns/100ps
`include "pih_params.svh"

module pih_interlock import pih_pkg::*; (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   arst_n_i,
	// Instruction from decode
	input  wire logic                   in_valid_i,
	input  wire pih_instr_s             in_instr_i,
	output logic                        in_ready_o,
	// Issue status
	output pih_issue_s                  issue_o,
	// Multiply write port
	input  wire logic                   rf_port_busy_i,
	output logic                        mdu_stall_o,
	// Hazard spacing still open, one bit per class
	output logic [`PIH_HZ_NUM-1:0]      hazard_pending_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	pih_instr_s  cand;
	logic        cand_valid;
	pih_wait_t   cnt      [`PIH_NUM_GPR];
	pih_wait_t   next_cnt [`PIH_NUM_GPR];
	pih_space_t  hz       [`PIH_HZ_NUM];
	pih_space_t  next_hz  [`PIH_HZ_NUM];
	logic [4:0]  mul_dest;
	logic        mul_pend;
	logic        fire;
	logic        hold;
	pih_instr_s  next_cand;
	logic        next_valid;
	logic        nx_ag;
	logic        nx_ex;

	// Wait a producer leaves on its destination
	function automatic pih_wait_t prod_wait(input pih_op_e op);
		unique case (op)
			OP_LOAD:                                   prod_wait = `PIH_WAIT_LOAD;
			OP_SYSREG_READ:                            prod_wait = `PIH_WAIT_SYSREG_RD;
			OP_REG_MULTIPLY, OP_MOVE_FROM_HIGH,
			OP_MOVE_FROM_LOW:                          prod_wait = `PIH_WAIT_MULTIPLY;
			default:                                   prod_wait = `PIH_WAIT_NONE;
		endcase
	endfunction

	// Spacing an issued instruction opens on hazard class k
	function automatic pih_space_t hz_set(input pih_instr_s i, input int k);
		logic xl;
		logic wr;
		logic ls;
		logic fe;
		xl = (i.op == OP_XLATE_WRITE_RANDOM) || (i.op == OP_XLATE_WRITE_INDEXED);
		wr = (i.op == OP_SYSREG_WRITE);
		ls = wr && (i.target inside {SR_ADDR_SPACE_ID, SR_ERROR_LEVEL,
			SR_DEBUG_LS_NORMAL_MEM});
		fe = xl || (i.op == OP_CACHE_IWRITE) || (wr && (i.target inside {
			SR_COPROC_USABLE, SR_FLOAT_REG_MODE, SR_ADDR_SPACE_ID,
			SR_ERROR_LEVEL, SR_EXCEPTION_LEVEL, SR_WATCH}));
		hz_set = 4'h0;
		case (k)
			`PIH_HZ_XLATE_LS:  if (xl) hz_set = `PIH_SP_XLATE_LS;
			`PIH_HZ_SYSREG_RD: if (wr) hz_set = `PIH_SP_SYSREG_RD;
			`PIH_HZ_TIMER:     if (wr && i.target == SR_TIMER_CMP) begin
				hz_set = `PIH_SP_TIMER;
			end
			`PIH_HZ_COPROC:    if (wr && (i.target inside {SR_COPROC_USABLE,
				SR_FLOAT_REG_MODE})) hz_set = `PIH_SP_COPROC;
			`PIH_HZ_LS_STATE:  if (ls) hz_set = `PIH_SP_LS_STATE;
			`PIH_HZ_OTHER:     if (wr) hz_set = `PIH_SP_OTHER;
			`PIH_HZ_FETCH:     if (fe) hz_set = `PIH_SP_FETCH;
			default:           hz_set = 4'h0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Issue decision
	// ------------------------------------------------------------------
	// Stall flag is computed a cycle ahead so it comes from a flop
	assign fire = cand_valid && !issue_o.stall;

	// Multiply result waits while the integer pipe owns the write port
	assign hold = mul_pend && (cnt[mul_dest] == 3'h1) && rf_port_busy_i;

	// Per-register countdown of producer latency
	generate
		for (genvar r = 0; r < `PIH_NUM_GPR; r++) begin : g_gpr
			always_comb begin
				if (r == 0) begin
					next_cnt[r] = 3'h0;                                 // Zero register never waits
				end else if (fire && cand.dest == 5'(r) && prod_wait(cand.op) != 3'h0) begin
					next_cnt[r] = prod_wait(cand.op);
				end else if (cnt[r] != 3'h0 && !(hold && mul_dest == 5'(r))) begin
					next_cnt[r] = cnt[r] - 3'h1;
				end else begin
					next_cnt[r] = cnt[r];
				end
			end
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					cnt[r] <= 3'h0;
				end else begin
					cnt[r] <= next_cnt[r];
				end
			end
		end
	endgenerate

	// Next held instruction and its hazard against next counts
	always_comb begin
		next_cand  = cand;
		next_valid = cand_valid;
		if (in_valid_i && in_ready_o) begin
			next_cand  = in_instr_i;
			next_valid = 1'b1;
		end else if (fire) begin
			next_valid = 1'b0;
		end
		// Base operands slip in address generation, ALU operands in execute
		nx_ag = (next_cand.use_a == USE_BASE && next_cnt[next_cand.src_a] != 3'h0)
			|| (next_cand.use_b == USE_BASE && next_cnt[next_cand.src_b] != 3'h0);
		nx_ex = (next_cand.use_a == USE_ALU && next_cnt[next_cand.src_a] > 3'h1)
			|| (next_cand.use_b == USE_ALU && next_cnt[next_cand.src_b] > 3'h1);
	end

	// Held instruction register
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cand       <= '0;
			cand_valid <= 1'b0;
		end else begin
			cand       <= next_cand;
			cand_valid <= next_valid;
		end
	end

	// Registered issue status and ready
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			issue_o    <= '{fire: 1'b0, stall: 1'b0, slip: SLIP_NONE};
			in_ready_o <= 1'b1;
		end else begin
			issue_o.stall <= next_valid && (nx_ag || nx_ex);
			issue_o.fire  <= next_valid && !(nx_ag || nx_ex);
			issue_o.slip  <= !next_valid ? SLIP_NONE : nx_ag ? SLIP_AG :
				nx_ex ? SLIP_EX : SLIP_NONE;
			in_ready_o    <= !(next_valid && (nx_ag || nx_ex));
		end
	end

	// Multiply destination tracking for write port arbitration
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mul_dest    <= 5'h00;
			mul_pend    <= 1'b0;
			mdu_stall_o <= 1'b0;
		end else begin
			mdu_stall_o <= hold;
			if (fire && cand.op == OP_REG_MULTIPLY && cand.dest != 5'h00) begin
				mul_dest <= cand.dest;
				mul_pend <= 1'b1;
			end else if (mul_pend && next_cnt[mul_dest] == 3'h0) begin
				mul_pend <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Hazard spacing counters
	// ------------------------------------------------------------------
	// Counted in issued instructions, not cycles, since spacing is
	// defined by intervening instructions; stalls do not shorten it
	generate
		for (genvar k = 0; k < `PIH_HZ_NUM; k++) begin : g_hz
			always_comb begin
				next_hz[k] = hz[k];
				if (fire) begin
					if (cand.op inside {OP_EXCEPTION_RETURN, OP_JUMP_BARRIER,
						OP_JUMP_LINK_BARRIER}) begin
						next_hz[k] = 4'h0;
					end else if (cand.op == OP_EXEC_BARRIER && k != `PIH_HZ_FETCH) begin
						next_hz[k] = 4'h0;
					end else if (hz_set(cand, k) > hz[k]) begin
						next_hz[k] = hz_set(cand, k);                    // New producer wins only if its spacing exceeds the count left
					end else if (hz[k] != 4'h0) begin
						next_hz[k] = hz[k] - 4'h1;
					end
				end
			end
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					hz[k]               <= 4'h0;
					hazard_pending_o[k] <= 1'b0;
				end else begin
					hz[k]               <= next_hz[k];
					hazard_pending_o[k] <= (next_hz[k] != 4'h0);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_load_fire;
		fire && cand.op == OP_LOAD && cand.dest != 5'h00;
	endsequence

	chk_load_alu_wait: assert property (s_load_fire ##1 (cand_valid && cand.use_a == USE_ALU
		&& cand.src_a == $past(cand.dest)) |-> issue_o.stall ##1 !(cnt[cand.src_a] > 3'h1))
		else $error("load to ALU consumer wait wrong");
	chk_load_base_cnt: assert property (s_load_fire |=> cnt[$past(cand.dest)] == 3'h2)
		else $error("load base wait not two");
	chk_sysrd_base_cnt: assert property (fire && cand.op == OP_SYSREG_READ
		&& cand.dest != 5'h00 |=> cnt[$past(cand.dest)] == 3'h3)
		else $error("sysreg read wait not three");
	chk_mul_base_cnt: assert property (fire && cand.op == OP_MOVE_FROM_LOW
		&& cand.dest != 5'h00 |=> cnt[$past(cand.dest)] == 3'h5)
		else $error("multiply result wait not five");
	chk_base_slip_ag: assert property (cand_valid && cand.use_a == USE_BASE
		&& cnt[cand.src_a] != 3'h0 |-> issue_o.stall && issue_o.slip == SLIP_AG)
		else $error("base consumer not slipped in address stage");
	chk_free_issue: assert property (cand_valid && cand.use_a == USE_NONE
		&& cand.use_b == USE_NONE |-> issue_o.fire && !issue_o.stall)
		else $error("independent instruction stalled");
	chk_xlate_space: assert property (fire && cand.op == OP_XLATE_WRITE_INDEXED
		|=> hz[`PIH_HZ_XLATE_LS] == 4'h3 && hz[`PIH_HZ_FETCH] == 4'ha)
		else $error("translation write spacing wrong");
	chk_timer_space: assert property (fire && cand.op == OP_SYSREG_WRITE
		&& cand.target == SR_TIMER_CMP |=> hazard_pending_o[`PIH_HZ_TIMER])
		else $error("timer compare spacing not opened");
	chk_barrier_clear: assert property (fire && cand.op == OP_JUMP_BARRIER
		|=> hazard_pending_o == '0)
		else $error("barrier did not clear hazards");
	chk_port_hold: assert property (hold |=> mdu_stall_o && cnt[mul_dest] == 3'h1)
		else $error("multiply not held for write port");

endmodule

// >>> sim/pih_interlock_tb.sv
/*
 * Self-checking bench for the issue interlock and hazard spacing block.
 * Assumes the package and constants header are compiled first and
 * that the design is the only source of issue status and hazard flags.
 */
`timescale 1ns/100ps
`include "pih_params.svh"

module pih_interlock_tb import pih_pkg::*; ();

	// ------------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------------
	logic                          clk_i;
	logic                          arst_n_i;
	logic                          in_valid_i;
	pih_instr_s                    in_instr_i;
	logic                          in_ready_o;
	pih_issue_s                    issue_o;
	logic                          rf_port_busy_i;
	logic                          mdu_stall_o;
	logic [`PIH_HZ_NUM-1:0]        hazard_pending_o;
	int                            fails;
	int                            compares;
	int                            cycles;
	int                            fires;
	int                            n;
	int                            k;
	int                            j;
	int                            t0;
	pih_slip_e                     sl;
	logic                          m;
	// Producer table: ALU wait, base wait is one more
	pih_op_e     prod[5] = '{OP_LOAD, OP_SYSREG_READ, OP_REG_MULTIPLY, OP_MOVE_FROM_HIGH,
		OP_MOVE_FROM_LOW};
	int          dalu[5] = '{1, 2, 4, 4, 4};
	// Hazard table: producer, target, flag bit, spacing
	pih_op_e     hop[12] = '{OP_XLATE_WRITE_RANDOM, OP_XLATE_WRITE_INDEXED, OP_SYSREG_WRITE,
		OP_SYSREG_WRITE, OP_SYSREG_WRITE, OP_SYSREG_WRITE, OP_SYSREG_WRITE, OP_SYSREG_WRITE,
		OP_SYSREG_WRITE, OP_SYSREG_WRITE, OP_SYSREG_WRITE, OP_CACHE_IWRITE};
	pih_sysreg_e htg[12] = '{SR_OTHER, SR_OTHER, SR_WATCH, SR_TIMER_CMP, SR_COPROC_USABLE,
		SR_FLOAT_REG_MODE, SR_ADDR_SPACE_ID, SR_ERROR_LEVEL, SR_DEBUG_LS_NORMAL_MEM,
		SR_OTHER, SR_EXCEPTION_LEVEL, SR_OTHER};
	int          hbit[12] = '{0, 6, 1, 2, 3, 3, 4, 4, 4, 5, 6, 6};
	int          hsp[12]  = '{3, 10, 2, 4, 4, 4, 3, 3, 3, 2, 10, 10};

	pih_interlock pih_interlock_inst (
		.clk_i            (clk_i),
		.arst_n_i         (arst_n_i),
		.in_valid_i       (in_valid_i),
		.in_instr_i       (in_instr_i),
		.in_ready_o       (in_ready_o),
		.issue_o          (issue_o),
		.rf_port_busy_i   (rf_port_busy_i),
		.mdu_stall_o      (mdu_stall_o),
		.hazard_pending_o (hazard_pending_o)
	);

	// ------------------------------------------------------------------
	// Clock, cycle ceiling and fire counter
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	// Sampled at the falling edge, where registered outputs have settled
	always @(negedge clk_i) begin
		if (issue_o.fire === 1'b1) fires++;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic pih_instr_s mk(input pih_op_e op, input pih_sysreg_e tg,
		input logic [4:0] d, input logic [4:0] sa, input pih_use_e ua,
		input logic [4:0] sb, input pih_use_e ub);
		mk = '{op, tg, d, sa, ua, sb, ub};
	endfunction

	function automatic pih_instr_s bare(input pih_op_e op, input pih_sysreg_e tg);
		bare = mk(op, tg, 5'h00, 5'h00, USE_NONE, 5'h00, USE_NONE);
	endfunction

	// Offer one instruction; returns once it will be taken at the next rise
	task automatic send(input pih_instr_s ins);
		int g;
		@(negedge clk_i);
		in_valid_i = 1'b1;
		in_instr_i = ins;
		g = 0;
		while (in_ready_o !== 1'b1 && g < 20) begin
			@(negedge clk_i);
			g++;
		end
	endtask

	task automatic idle(input int c);
		@(negedge clk_i);
		in_valid_i = 1'b0;
		repeat (c) @(negedge clk_i);
	endtask

	// Count stall cycles of the last instruction taken, up to its fire
	task automatic watch(output int cnt, output pih_slip_e s, output logic md);
		int g;
		cnt = 0;
		s = SLIP_NONE;
		md = 1'b0;
		@(negedge clk_i);
		in_valid_i = 1'b0;
		for (g = 0; g < 30 && issue_o.fire !== 1'b1; g++) begin
			if (issue_o.stall === 1'b1) begin
				cnt++;
				s = issue_o.slip;
				check(in_ready_o, 1'b0, "ready while stalled");
			end
			md = md | (mdu_stall_o === 1'b1);
			@(negedge clk_i);
		end
	endtask

	task automatic rst_check();
		check(in_ready_o, 1'b1, "ready in reset");
		check(issue_o, '0, "issue in reset");
		check(mdu_stall_o, 1'b0, "port stall in reset");
		check(hazard_pending_o, '0, "hazards in reset");
	endtask

	task automatic finish_test();
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		arst_n_i = 1'b0;
		in_valid_i = 1'b0;
		in_instr_i = bare(OP_OTHER, SR_OTHER);
		rf_port_busy_i = 1'b0;
		repeat (10) @(negedge clk_i);
		rst_check();
		arst_n_i = 1'b1;
		// Independent instructions back to back, one per cycle
		t0 = fires;
		send(mk(OP_ALU, SR_OTHER, 5'h03, 5'h01, USE_ALU, 5'h02, USE_ALU));
		j = cycles;
		for (k = 0; k < 3; k++)
			send(mk(OP_LOAD, SR_OTHER, 5'h04, 5'h01, USE_BASE, 5'h02, USE_ALU));
		check(cycles - j, 16'h3, "back to back spacing");
		idle(3);
		check(fires - t0, 16'h4, "fires back to back");
		// Every producer against an ALU and a base consumer
		for (k = 0; k < 5; k++) begin
			send(mk(prod[k], SR_OTHER, 5'h05, 5'h00, USE_NONE, 5'h00, USE_NONE));
			send(mk(OP_ALU, SR_OTHER, 5'h06, 5'h05, USE_ALU, 5'h00, USE_NONE));
			watch(n, sl, m);
			check(n, dalu[k], "alu consumer stalls");
			check(sl, SLIP_EX, "alu consumer slip");
			send(mk(prod[k], SR_OTHER, 5'h05, 5'h00, USE_NONE, 5'h00, USE_NONE));
			send(mk(OP_STORE, SR_OTHER, 5'h00, 5'h01, USE_ALU, 5'h05, USE_BASE));
			watch(n, sl, m);
			check(n, dalu[k] + 1, "base consumer stalls");
			check(sl, SLIP_AG, "base consumer slip");
		end
		// Unrelated register and register zero never wait
		send(mk(OP_LOAD, SR_OTHER, 5'h05, 5'h00, USE_NONE, 5'h00, USE_NONE));
		send(mk(OP_LOAD, SR_OTHER, 5'h07, 5'h06, USE_BASE, 5'h00, USE_NONE));
		watch(n, sl, m);
		check(n, 16'h0, "unrelated operand stalls");
		send(mk(OP_REG_MULTIPLY, SR_OTHER, 5'h00, 5'h00, USE_NONE, 5'h00, USE_NONE));
		send(mk(OP_ALU, SR_OTHER, 5'h07, 5'h00, USE_ALU, 5'h00, USE_BASE));
		watch(n, sl, m);
		check(n, 16'h0, "register zero stalls");
		// Register write port busy holds the multiply result back; a base
		// consumer sees it, ALU consumers already took the bypassed result
		rf_port_busy_i = 1'b1;
		send(mk(OP_REG_MULTIPLY, SR_OTHER, 5'h09, 5'h00, USE_NONE, 5'h00, USE_NONE));
		send(mk(OP_LOAD, SR_OTHER, 5'h0a, 5'h09, USE_BASE, 5'h00, USE_NONE));
		fork
			begin
				repeat (10) @(negedge clk_i);
				rf_port_busy_i = 1'b0;
			end
		join_none
		watch(n, sl, m);
		check(n > 5, 1'b1, "held multiply stalls longer");
		check(m, 1'b1, "port stall seen");
		idle(3);
		check(mdu_stall_o, 1'b0, "port stall released");
		// Each hazard class: open one short of its spacing, closed at it
		for (k = 0; k < 12; k++) begin
			send(bare(OP_EXCEPTION_RETURN, SR_OTHER));
			send(bare(hop[k], htg[k]));
			for (j = 0; j < hsp[k] - 1; j++) send(bare(OP_OTHER, SR_OTHER));
			idle(3);
			m = hazard_pending_o[hbit[k]];
			check(m, 1'b1, "hazard still open");
			send(bare(OP_OTHER, SR_OTHER));
			idle(3);
			m = hazard_pending_o[hbit[k]];
			check(m, 1'b0, "hazard closed");
		end
		// Barriers: execution barrier leaves fetch hazards open
		send(bare(OP_XLATE_WRITE_INDEXED, SR_OTHER));
		send(bare(OP_EXEC_BARRIER, SR_OTHER));
		idle(3);
		check(hazard_pending_o[0], 1'b0, "exec barrier clears");
		check(hazard_pending_o[6], 1'b1, "exec barrier keeps fetch");
		send(bare(OP_JUMP_BARRIER, SR_OTHER));
		idle(3);
		check(hazard_pending_o, '0, "jump barrier clears");
		send(bare(OP_SYSREG_WRITE, SR_WATCH));
		send(bare(OP_JUMP_LINK_BARRIER, SR_OTHER));
		idle(3);
		check(hazard_pending_o, '0, "jump link barrier clears");
		// Reset in mid-run drops open hazards
		send(bare(OP_CACHE_IWRITE, SR_OTHER));
		idle(2);
		arst_n_i = 1'b0;
		idle(2);
		rst_check();
		arst_n_i = 1'b1;
		idle(2);
		finish_test();
	end

endmodule
